// ===== host_status_pkg.sv
// Constants for the host-side status register of the parallel host port.
// Assumes a single 10 MHz system clock and a host bus with a 3-bit register address.
package host_status_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Address of the status register on the host bus; the value is arbitrary.
  localparam logic [2:0] STATUS_ADDR = 3'h2;
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_FLAG2 = 3;
  localparam int BIT_FLAG3 = 4;
  localparam int BIT_REQUEST = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] RESERVED_MASK = 8'h64;
endpackage

// ===== host_request_merge.sv
// Request pin logic: turns full and empty flags plus their enables into request pins.
// Assumes flags and enables are synchronous to SYS_CLK and the software reset is one cycle.
`timescale 1ns/1ps
module host_request_merge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic receive_full_flag,
  input wire logic transmit_empty_flag,
  input wire logic receive_request_enable,
  input wire logic transmit_request_enable,
  input wire logic dual_request_select,
  output logic host_request_pin,
  output logic transmit_request_pin,
  output logic receive_request_pin,
  output logic host_request_indication
);
  typedef struct packed {
    logic combined;
    logic tx_req;
    logic rx_req;
    logic indication;
  } req_s;

  req_s cur_ff;
  req_s nxt_cur;
  logic rx_src;
  logic tx_src;

  always_comb
  begin
    nxt_cur = cur_ff;
    // A cleared enable masks its source, leaving the host to poll.
    rx_src = receive_full_flag & receive_request_enable;
    tx_src = transmit_empty_flag & transmit_request_enable;
    nxt_cur.combined = (rx_src | tx_src) & ~dual_request_select;
    nxt_cur.tx_req = tx_src & dual_request_select;
    nxt_cur.rx_req = rx_src & dual_request_select;
    // The status bit follows whichever pin set is active, so it equals what the host sees.
    if (dual_request_select)
    begin
      nxt_cur.indication = nxt_cur.tx_req | nxt_cur.rx_req;
    end
    else
    begin
      nxt_cur.indication = nxt_cur.combined;
    end
    if (soft_reset)
    begin
      nxt_cur = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign host_request_pin = cur_ff.combined;
  assign transmit_request_pin = cur_ff.tx_req;
  assign receive_request_pin = cur_ff.rx_req;
  assign host_request_indication = cur_ff.indication;
endmodule // host_request_merge

// ===== host_status_register.sv
// Host-side status register of the parallel host port, with its request pins.
// Assumes host strobes are one-cycle pulses synchronous to SYS_CLK; the core has no access.
`timescale 1ns/1ps
// Notes on behaviour
// - Status register is eight bits, read only; host writes change nothing.
// - Only the host side can reach the status register; core has no port.
// - With dual requests selected, bit 7 shows the transmit and receive request pins.
// - With dual requests off, the request bit shows the combined request pin.
// - Request set when receive full or transmit empty is set with its enable.
// - In single mode, 0 means no host interrupt and 1 means one requested.
// - Receive enable with receive full asserts the request; cleared enable masks it.
module host_status_register (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SOFT_RESET,
  input wire logic [2:0] HOST_ADDR,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic RECEIVE_FULL_FLAG,
  input wire logic TRANSMIT_EMPTY_FLAG,
  input wire logic RECEIVE_REQUEST_ENABLE,
  input wire logic TRANSMIT_REQUEST_ENABLE,
  input wire logic DUAL_REQUEST_SELECT,
  input wire logic HOST_FLAG2,
  input wire logic HOST_FLAG3,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RVALID,
  output logic HOST_REQUEST_PIN,
  output logic TRANSMIT_REQUEST_PIN,
  output logic RECEIVE_REQUEST_PIN
);
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } rd_s;

  rd_s rd_ff;
  rd_s nxt_rd;
  logic host_request_indication;
  logic [7:0] status_value;

  function automatic logic hits_status(input logic [2:0] addr);
    hits_status = (addr == host_status_pkg::STATUS_ADDR);
  endfunction

  host_request_merge u_merge (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .soft_reset(SOFT_RESET),
    .receive_full_flag(RECEIVE_FULL_FLAG),
    .transmit_empty_flag(TRANSMIT_EMPTY_FLAG),
    .receive_request_enable(RECEIVE_REQUEST_ENABLE),
    .transmit_request_enable(TRANSMIT_REQUEST_ENABLE),
    .dual_request_select(DUAL_REQUEST_SELECT),
    .host_request_pin(HOST_REQUEST_PIN),
    .transmit_request_pin(TRANSMIT_REQUEST_PIN),
    .receive_request_pin(RECEIVE_REQUEST_PIN),
    .host_request_indication(host_request_indication)
  );

  always_comb
  begin
    status_value = host_status_pkg::STATUS_RESET;
    status_value[host_status_pkg::BIT_RX_FULL] = RECEIVE_FULL_FLAG;
    status_value[host_status_pkg::BIT_TX_EMPTY] = TRANSMIT_EMPTY_FLAG;
    status_value[host_status_pkg::BIT_FLAG2] = HOST_FLAG2;
    status_value[host_status_pkg::BIT_FLAG3] = HOST_FLAG3;
    status_value[host_status_pkg::BIT_REQUEST] = host_request_indication;
    status_value = status_value & ~host_status_pkg::RESERVED_MASK;
  end

  always_comb
  begin
    nxt_rd = rd_ff;
    nxt_rd.rvalid = 1'h0;
    // Only reads are decoded; a host write to this address is dropped, so the
    // register cannot be corrupted by a stray store.
    if (HOST_RD && hits_status(HOST_ADDR))
    begin
      nxt_rd.rdata = status_value;
      nxt_rd.rvalid = 1'h1;
    end
    if (SOFT_RESET)
    begin
      nxt_rd = '0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_ff <= '0;
    end
    else
    begin
      rd_ff <= nxt_rd;
    end
  end

  // Write data and strobe exist only to complete the bus; they are deliberately unused.
  logic unused_wr;
  assign unused_wr = HOST_WR ^ (^HOST_WDATA);
  assign HOST_RDATA = rd_ff.rdata;
  assign HOST_RVALID = rd_ff.rvalid;
endmodule // host_status_register

// ===== host_status_monitor.sv
// Checker bound to the host status register.
// Assumes one clock domain.
`timescale 1ns/1ps
module host_status_monitor (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SOFT_RESET,
  input wire logic HOST_RD,
  input wire logic DUAL_REQUEST_SELECT,
  input wire logic HOST_RVALID,
  input wire logic RECEIVE_FULL_FLAG,
  input wire logic TRANSMIT_EMPTY_FLAG,
  input wire logic RECEIVE_REQUEST_ENABLE,
  input wire logic TRANSMIT_REQUEST_ENABLE,
  input wire logic HOST_REQUEST_PIN,
  input wire logic TRANSMIT_REQUEST_PIN,
  input wire logic RECEIVE_REQUEST_PIN,
  input wire logic [2:0] HOST_ADDR,
  input wire logic [7:0] HOST_RDATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire r = RECEIVE_FULL_FLAG & RECEIVE_REQUEST_ENABLE;
  wire t = TRANSMIT_EMPTY_FLAG & TRANSMIT_REQUEST_ENABLE;
  wire d = DUAL_REQUEST_SELECT & !SOFT_RESET;
  wire s = !DUAL_REQUEST_SELECT & !SOFT_RESET;
  wire q = HOST_REQUEST_PIN | TRANSMIT_REQUEST_PIN | RECEIVE_REQUEST_PIN;
  wire g = HOST_RD && HOST_ADDR == host_status_pkg::STATUS_ADDR;
  property p_one; s |=> HOST_REQUEST_PIN == $past(r | t); endproperty
  a_one: assert property (p_one) else $error("combined pin");
  property p_tx; d |=> TRANSMIT_REQUEST_PIN == $past(t); endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  property p_rx; d |-> ##1 RECEIVE_REQUEST_PIN == $past(r); endproperty
  a_rx: assert property (p_rx) else $error("rx pin");
  property p_rd; !SOFT_RESET |=> HOST_RVALID == $past(g); endproperty
  a_rd: assert property (p_rd) else $error("valid");
  property p_b7; HOST_RVALID |-> HOST_RDATA[7] == $past(q); endproperty
  a_b7: assert property (p_b7) else $error("bit 7");
  property p_sr; SOFT_RESET |=> !q && !HOST_RVALID && HOST_RDATA == 8'h00; endproperty
  a_sr: assert property (p_sr) else $error("soft reset");
  property p_rz;
    HOST_RVALID |-> (HOST_RDATA & host_status_pkg::RESERVED_MASK) == 8'h00;
  endproperty
  a_rz: assert property (p_rz) else $error("reserved");
  property p_hd; !HOST_RVALID && !$past(SOFT_RESET) |-> $stable(HOST_RDATA); endproperty
  a_hd: assert property (p_hd) else $error("data moved");
endmodule // host_status_monitor
bind host_status_register host_status_monitor mon_u (.*);

// ===== host_bus_model.sv
// Host processor model: one-cycle read or write strobes.
// Assumes strobes are sampled on the rising edge.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  output logic [2:0] addr = 3'h0,
  output logic rd = 1'h0,
  output logic wr = 1'h0,
  output logic [7:0] wdata = 8'h00
);
  // Released address and data lines show the inverse and both strobes drop, so a stale value is never mistaken for a live one.
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    {addr, rd, wr, wdata} = {a, !w, w, v};
    @(negedge clk);
    {addr, rd, wr, wdata} = {~a, 2'h0, ~v};
  endtask
endmodule // host_bus_model

// ===== host_status_register_test.sv
// Self-checking bench for the host status register.
// Assumes the host model drives the bus.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("FAIL %0t %h %h", $time, a, b); \
    end \
  end
module host_status_register_test;
  logic SYS_CLK = '0, RST_N = '0, SOFT_RESET = '0, HOST_FLAG2 = '0, HOST_FLAG3 = '0;
  logic RECEIVE_FULL_FLAG = '0, TRANSMIT_EMPTY_FLAG = '0, DUAL_REQUEST_SELECT = '0;
  logic RECEIVE_REQUEST_ENABLE = '0, TRANSMIT_REQUEST_ENABLE = '0, HOST_RD, HOST_WR;
  logic HOST_RVALID, HOST_REQUEST_PIN, TRANSMIT_REQUEST_PIN, RECEIVE_REQUEST_PIN;
  logic [2:0] HOST_ADDR;
  logic [7:0] HOST_WDATA, HOST_RDATA;
  int fails = 0, compares = 0;
  wire [11:0] outs = {HOST_REQUEST_PIN, TRANSMIT_REQUEST_PIN, RECEIVE_REQUEST_PIN,
    HOST_RVALID, HOST_RDATA};
  host_status_register dut_u (.*);
  host_bus_model host_u (
    .clk(SYS_CLK),
    .addr(HOST_ADDR),
    .rd(HOST_RD),
    .wr(HOST_WR),
    .wdata(HOST_WDATA)
  );
  initial forever #50 SYS_CLK = ~SYS_CLK;
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic read_check(input logic [7:0] exp);
    host_u.access(1'h0, host_status_pkg::STATUS_ADDR, 8'h00);
    `CHK({HOST_RVALID, HOST_RDATA}, {1'h1, exp})
  endtask
  task automatic t_req;
    logic r, t;
    for (int i = 0; i < 32; i++)
    begin
      @(negedge SYS_CLK);
      {DUAL_REQUEST_SELECT, RECEIVE_FULL_FLAG, TRANSMIT_EMPTY_FLAG, RECEIVE_REQUEST_ENABLE,
        TRANSMIT_REQUEST_ENABLE} = i[4:0];
      {HOST_FLAG3, HOST_FLAG2} = i[1:0] ^ i[3:2];
      r = RECEIVE_FULL_FLAG & RECEIVE_REQUEST_ENABLE;
      t = TRANSMIT_EMPTY_FLAG & TRANSMIT_REQUEST_ENABLE;
      @(negedge SYS_CLK);
      `CHK(outs[11:9], DUAL_REQUEST_SELECT ? {1'h0, t, r} : {r | t, 2'h0})
      read_check({r | t, 2'h0, HOST_FLAG3, HOST_FLAG2, 1'h0, i[2], i[3]});
    end
  endtask
  task automatic t_refuse;
    host_u.access(1'h1, host_status_pkg::STATUS_ADDR, 8'hFF);
    `CHK(HOST_RVALID, 1'h0)
    host_u.access(1'h0, 3'h5, 8'h00);
    `CHK(outs[8:0], 9'h083)
    read_check(8'h83);
  endtask
  task automatic t_soft;
    @(negedge SYS_CLK);
    SOFT_RESET = 1'h1;
    @(negedge SYS_CLK);
    `CHK(outs, 12'h000)
    SOFT_RESET = 1'h0;
    @(negedge SYS_CLK);
    `CHK(outs[11:9], 3'h3)
  endtask
  initial
  begin
    repeat (2) @(negedge SYS_CLK);
    `CHK(outs, 12'h000)
    RST_N = 1'h1;
    t_req();
    t_refuse();
    t_soft();
    finish_test();
  end
  initial
  begin
    #100000;
    fails++;
    finish_test();
  end
endmodule // host_status_register_test
